//--- bench/low_freq_osc_control_bench.sv
// Self-checking bench for the 32 kHz oscillator control block
`timescale 1ns/1ps
module low_freq_osc_control_bench;
	// -----------------------------------------------
	// Stimulus and observed signals
	// -----------------------------------------------
	logic        mclk_in;
	logic        rst_n_in;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        err;
	logic        ulp;
	logic        xclk;
	logic        rclk;
	logic        xreq;
	logic        rreq;
	logic [4:0]  tload;
	logic        x_run;
	logic        x_amp;
	logic        x_pad;
	logic        x_gate;
	logic        r_run;
	logic        r_gate;
	logic [6:0]  r_trim;
	logic [4:0]  u_trim;
	logic        x_rdy;
	logic        r_rdy;
	logic        irq;
	int          tick = 0;
	int          fail_count;
	int          compares;

	lfo_ctrl u_lfo_ctrl (
		.mclk_in          (mclk_in),
		.rst_n_in         (rst_n_in),
		.wb_cyc_in        (cyc),
		.wb_stb_in        (stb),
		.wb_we_in         (we),
		.wb_adr_in        (adr),
		.wb_sel_in        (sel),
		.wb_dat_in        (wdat),
		.wb_dat_out       (rdat),
		.wb_ack_out       (ack),
		.wb_err_out       (err),
		.ulp_clk_in       (ulp),
		.ext_clk_in       (xclk),
		.rc_clk_in        (rclk),
		.ext_req_in       (xreq),
		.rc_req_in        (rreq),
		.ulp_trim_load_in (tload),
		.ext_run_out      (x_run),
		.ext_amp_ctrl_out (x_amp),
		.ext_pad_xtal_out (x_pad),
		.ext_out_gate_out (x_gate),
		.rc_run_out       (r_run),
		.rc_out_gate_out  (r_gate),
		.rc_trim_out      (r_trim),
		.ulp_trim_out     (u_trim),
		.ext_ready_out    (x_rdy),
		.rc_ready_out     (r_rdy),
		.irq_out          (irq)
	);

	// -----------------------------------------------
	// Clocks; oscillators kept well under mclk/2
	// -----------------------------------------------
	initial
	begin
		mclk_in = 1'h0;
		forever #2 mclk_in = ~mclk_in;
	end

	always_ff @(posedge mclk_in)
	begin
		tick <= tick + 1;
		ulp <= (tick % 10) < 5;
		xclk <= (tick % 12) < 6;
		rclk <= (tick % 14) < 7;
	end

	// -----------------------------------------------
	// Checking and bus tasks
	// -----------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// Holds the request until ack or err is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge mclk_in);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (ack !== 1'h1 && err !== 1'h1 && n < 50);
		q = rdat;
		e = err;
		chk(32'(n < 50), 32'h1);
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'h1, a, d, q, e);
		chk(32'(e), 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		xfer(1'h0, a, 32'h0, q, e);
		chk(q, x);
	endtask : rd

	task automatic wait_rdy(input logic rc);
		int n;
		n = 0;
		while ((rc ? r_rdy : x_rdy) !== 1'h1 && n < 400)
		begin
			@(posedge mclk_in);
			n++;
		end
		chk(32'(n < 400), 32'h1);
	endtask : wait_rdy

	task automatic pause(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : pause

	// -----------------------------------------------
	// Watchdog
	// -----------------------------------------------
	initial
	begin
		pause(20000);
		fail_count++;
		tally_and_finish();
	end

	// -----------------------------------------------
	// Test sequence
	// -----------------------------------------------
	initial
	begin
		logic [31:0] q;
		logic        e;
		fail_count = 0;
		compares = 0;
		rst_n_in = 1'h0;
		{cyc, stb, we, xreq, rreq} = 5'h00;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0;
		tload = 5'h0B;
		pause(16);
		rst_n_in <= 1'h1;
		pause(4);
		// Reset values and unmapped access
		rd(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_0080);
		rd(lfo_pkg::ADDR_INT_RC, 32'h003F_0080);
		rd(lfo_pkg::ADDR_ULP, 32'h0000_000B);
		chk(32'(u_trim), 32'h0B);
		chk(32'({x_run, r_run, irq}), 32'h0);
		chk(32'({x_amp, x_pad, x_gate, r_gate}), 32'h0);
		xfer(1'h0, 8'h20, 32'h0, q, e);
		chk(32'(e), 32'h1);
		// Crystal always on, pads, gate, amplitude control
		wr(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_002E);
		pause(3);
		chk(32'({x_amp, x_pad, x_gate, x_run}), 32'hF);
		rd(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_002E);
		chk(32'(x_rdy), 32'h0);
		wait_rdy(1'h0);
		chk(32'(irq), 32'h0);
		wr(lfo_pkg::ADDR_IRQ_MASK, 32'h1);
		pause(2);
		chk(32'(irq), 32'h1);
		rd(lfo_pkg::ADDR_IRQ_FLAGS, 32'h1);
		pause(2);
		chk(32'(irq), 32'h0);
		// Request-driven crystal, output gate off
		wr(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_00A6);
		pause(4);
		chk(32'({x_run, x_rdy, x_gate}), 32'h0);
		xreq <= 1'h1;
		pause(4);
		chk(32'({x_run, x_gate}), 32'h2);
		wait_rdy(1'h0);
		rd(lfo_pkg::ADDR_IRQ_FLAGS, 32'h1);
		// RC oscillator with trim, start-up code 1
		wr(lfo_pkg::ADDR_IRQ_MASK, 32'h2);
		wr(lfo_pkg::ADDR_INT_RC, 32'h0055_0106);
		pause(3);
		chk(32'(r_trim), 32'h55);
		chk(32'({r_run, r_gate}), 32'h3);
		pause(27);
		chk(32'(r_rdy), 32'h0);
		wait_rdy(1'h1);
		pause(2);
		chk(32'(irq), 32'h1);
		rd(lfo_pkg::ADDR_STATUS, 32'h3);
		rd(lfo_pkg::ADDR_IRQ_FLAGS, 32'h2);
		rd(lfo_pkg::ADDR_IRQ_FLAGS, 32'h0);
		chk(32'(irq), 32'h0);
		// RC output gate off, then disable
		wr(lfo_pkg::ADDR_INT_RC, 32'h0055_0002);
		pause(3);
		chk(32'({r_run, r_gate}), 32'h2);
		wr(lfo_pkg::ADDR_INT_RC, 32'h0055_0000);
		pause(4);
		chk(32'({r_run, r_rdy}), 32'h0);
		// Request-driven RC oscillator follows its request
		wr(lfo_pkg::ADDR_INT_RC, 32'h0055_0082);
		pause(4);
		chk(32'(r_run), 32'h0);
		rreq <= 1'h1;
		pause(4);
		chk(32'(r_run), 32'h1);
		// Write locks survive later writes
		wr(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_102E);
		wr(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_0000);
		rd(lfo_pkg::ADDR_EXT_XTAL, 32'h0000_102E);
		pause(3);
		chk(32'(x_run), 32'h1);
		wr(lfo_pkg::ADDR_INT_RC, 32'h0012_1000);
		wr(lfo_pkg::ADDR_INT_RC, 32'h0000_0002);
		rd(lfo_pkg::ADDR_INT_RC, 32'h0012_1000);
		wr(lfo_pkg::ADDR_ULP, 32'h0000_009F);
		wr(lfo_pkg::ADDR_ULP, 32'h0000_0000);
		rd(lfo_pkg::ADDR_ULP, 32'h0000_009F);
		chk(32'(u_trim), 32'h1F);
		tally_and_finish();
	end
endmodule : low_freq_osc_control_bench

//--- core/lfo_ctrl.sv
// Control, start-up sequencing and Wishbone registers of 32 kHz oscillators
//
// Functional notes
// - Crystal register lock bit 12 blocks writes
// - Crystal start-up code selects ULP cycle count
// - Crystal ready after three more crystal cycles
// - Request-driven bit: run only when requested
// - Request-driven clear: enabled oscillator always runs
// - Crystal bit 5 drives amplitude control
// - Crystal bit 3 gates 32 kHz output
// - Crystal bit 2 selects crystal or clock pads
// - Bit 1 enables the crystal and RC oscillators
// - RC register lock bit 12 blocks writes
// - RC start-up code selects ULP cycle count
// - RC ready after two more RC cycles
// - RC bit 2 gates 32 kHz output
// - ULP register lock bit 7 blocks writes
// - ULP trim loaded from stored data
// - RC ready rise sets interrupt flag
`timescale 1ns/1ps
module lfo_ctrl #(
	parameter logic [4:0] ULP_TRIM_DEFAULT = 5'h10
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// Wishbone classic slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	output logic             wb_err_out,
	// Oscillator side, all asynchronous inputs
	input  wire logic        ulp_clk_in,
	input  wire logic        ext_clk_in,
	input  wire logic        rc_clk_in,
	input  wire logic        ext_req_in,
	input  wire logic        rc_req_in,
	input  wire logic [4:0]  ulp_trim_load_in,
	output logic             ext_run_out,
	output logic             ext_amp_ctrl_out,
	output logic             ext_pad_xtal_out,
	output logic             ext_out_gate_out,
	output logic             rc_run_out,
	output logic             rc_out_gate_out,
	output logic [6:0]       rc_trim_out,
	output logic [4:0]       ulp_trim_out,
	output logic             ext_ready_out,
	output logic             rc_ready_out,
	output logic             irq_out
);

	// ---------------------------------------------------------------
	// Reset release and input synchronisers
	// ---------------------------------------------------------------
	logic       rst_q1;
	logic       rst_n;
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] sync3;

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// Third stage only feeds edge detection, never the first stage
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			sync3 <= 5'h00;
		end
		else
		begin
			sync1 <= {rc_req_in, ext_req_in, rc_clk_in, ext_clk_in,
				ulp_clk_in};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	wire ulp_tick = sync2[0] & ~sync3[0];
	wire ext_tick = sync2[1] & ~sync3[1];
	wire rc_tick  = sync2[2] & ~sync3[2];
	wire ext_req  = sync2[3];
	wire rc_req   = sync2[4];

	// ---------------------------------------------------------------
	// Registers and bus decode
	// ---------------------------------------------------------------
	logic [31:0] ext_reg;
	logic [31:0] rc_reg;
	logic [7:0]  ulp_reg;
	logic [1:0]  irq_flags;
	logic [1:0]  irq_mask;
	logic        trim_loaded;
	logic [31:0] rd_mux;

	wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
		{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	wire req_now  = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
	wire hit_ext  = wb_adr_in == lfo_pkg::ADDR_EXT_XTAL;
	wire hit_rc   = wb_adr_in == lfo_pkg::ADDR_INT_RC;
	wire hit_ulp  = wb_adr_in == lfo_pkg::ADDR_ULP;
	wire hit_st   = wb_adr_in == lfo_pkg::ADDR_STATUS;
	wire hit_flg  = wb_adr_in == lfo_pkg::ADDR_IRQ_FLAGS;
	wire hit_msk  = wb_adr_in == lfo_pkg::ADDR_IRQ_MASK;
	wire mapped   = hit_ext | hit_rc | hit_ulp | hit_st | hit_flg | hit_msk;
	wire wr       = req_now & wb_we_in & mapped;
	wire rd_flags = req_now & ~wb_we_in & hit_flg;

	wire ext_locked = ext_reg[lfo_pkg::BIT_LOCK];
	wire rc_locked  = rc_reg[lfo_pkg::BIT_LOCK];
	wire ulp_locked = ulp_reg[lfo_pkg::BIT_ULP_LOCK];

	// Lock bit ORs in so it can never be cleared by software
	wire [31:0] ext_wm = bmask & lfo_pkg::WMASK_EXT;
	wire [31:0] next_ext = ext_locked ? ext_reg :
		((ext_reg & ~ext_wm) | (wb_dat_in & ext_wm)) |
		(ext_reg & (32'h1 << lfo_pkg::BIT_LOCK));
	wire [31:0] rc_wm = bmask & lfo_pkg::WMASK_RC;
	wire [31:0] next_rc = rc_locked ? rc_reg :
		((rc_reg & ~rc_wm) | (wb_dat_in & rc_wm)) |
		(rc_reg & (32'h1 << lfo_pkg::BIT_LOCK));
	wire [7:0] ulp_wm = bmask[7:0] & lfo_pkg::WMASK_ULP[7:0];
	wire [7:0] next_ulp = ulp_locked ? ulp_reg :
		(ulp_reg & ~ulp_wm) | (wb_dat_in[7:0] & ulp_wm);

	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_reg     <= lfo_pkg::RST_EXT_XTAL;
			rc_reg      <= lfo_pkg::RST_INT_RC;
			ulp_reg     <= {3'h0, ULP_TRIM_DEFAULT};
			irq_mask    <= 2'h0;
			trim_loaded <= 1'b0;
		end
		else
		begin
			if (!trim_loaded)
			begin
				ulp_reg[4:0] <= ulp_trim_load_in;
				trim_loaded  <= 1'b1;
			end
			else if (wr && hit_ulp)
				ulp_reg <= next_ulp;
			if (wr && hit_ext)
				ext_reg <= next_ext;
			if (wr && hit_rc)
				rc_reg <= next_rc;
			if (wr && hit_msk && wb_sel_in[0])
				irq_mask <= wb_dat_in[1:0];
		end
	end

	// ---------------------------------------------------------------
	// Start-up sequencers
	// ---------------------------------------------------------------
	function automatic logic [17:0] ext_count(input logic [2:0] code);
		unique case (code)
			3'h0: ext_count = 18'h00001;
			3'h1: ext_count = 18'h00020;
			3'h2: ext_count = 18'h00800;
			3'h3: ext_count = 18'h01000;
			3'h4: ext_count = 18'h04000;
			3'h5: ext_count = 18'h08000;
			3'h6: ext_count = 18'h10000;
			3'h7: ext_count = 18'h20000;
		endcase
	endfunction : ext_count

	function automatic logic [17:0] rc_count(input logic [2:0] code);
		unique case (code)
			3'h0: rc_count = 18'h00003;
			3'h1: rc_count = 18'h00004;
			3'h2: rc_count = 18'h00006;
			3'h3: rc_count = 18'h0000A;
			3'h4: rc_count = 18'h00012;
			3'h5: rc_count = 18'h00022;
			3'h6: rc_count = 18'h00042;
			3'h7: rc_count = 18'h00082;
		endcase
	endfunction : rc_count

	lfo_pkg::lfo_osc_cfg_s ext_cfg;
	lfo_pkg::lfo_osc_cfg_s rc_cfg;
	assign ext_cfg = '{req_run: ext_reg[lfo_pkg::BIT_REQ_RUN],
		enable: ext_reg[lfo_pkg::BIT_ENABLE],
		startup: ext_reg[lfo_pkg::STARTUP_LSB +: 3]};
	assign rc_cfg = '{req_run: rc_reg[lfo_pkg::BIT_REQ_RUN],
		enable: rc_reg[lfo_pkg::BIT_ENABLE],
		startup: rc_reg[lfo_pkg::STARTUP_LSB +: 3]};

	wire ext_run = ext_cfg.enable & (~ext_cfg.req_run | ext_req);
	wire rc_run  = rc_cfg.enable & (~rc_cfg.req_run | rc_req);

	logic [17:0] ext_cnt;
	logic [17:0] rc_cnt;
	logic [1:0]  ext_sync;
	logic [1:0]  rc_sync;
	logic        ext_rdy;
	logic        rc_rdy;
	logic        rc_rdy_q;

	wire ext_cnt_done = ext_cnt == 18'h00000;
	wire rc_cnt_done  = rc_cnt == 18'h00000;

	// Counter reloads while stopped, so every start begins afresh
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_cnt  <= 18'h00000;
			ext_sync <= 2'h0;
			ext_rdy  <= 1'b0;
		end
		else if (!ext_run)
		begin
			ext_cnt  <= ext_count(ext_cfg.startup);
			ext_sync <= 2'h0;
			ext_rdy  <= 1'b0;
		end
		else if (!ext_cnt_done)
		begin
			if (ulp_tick)
				ext_cnt <= ext_cnt - 18'h00001;
		end
		else if (!ext_rdy && ext_tick)
		begin
			if (ext_sync == 2'(lfo_pkg::SYNC_EXT - 1))
				ext_rdy <= 1'b1;
			else
				ext_sync <= ext_sync + 2'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rc_cnt  <= 18'h00000;
			rc_sync <= 2'h0;
			rc_rdy  <= 1'b0;
		end
		else if (!rc_run)
		begin
			rc_cnt  <= rc_count(rc_cfg.startup);
			rc_sync <= 2'h0;
			rc_rdy  <= 1'b0;
		end
		else if (!rc_cnt_done)
		begin
			if (ulp_tick)
				rc_cnt <= rc_cnt - 18'h00001;
		end
		else if (!rc_rdy && rc_tick)
		begin
			if (rc_sync == 2'(lfo_pkg::SYNC_RC - 1))
				rc_rdy <= 1'b1;
			else
				rc_sync <= rc_sync + 2'h1;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt flags: set wins over read-clear
	// ---------------------------------------------------------------
	logic ext_rdy_q;
	wire [1:0] rise = {rc_rdy & ~rc_rdy_q, ext_rdy & ~ext_rdy_q};

	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rc_rdy_q  <= 1'b0;
			ext_rdy_q <= 1'b0;
			irq_flags <= 2'h0;
		end
		else
		begin
			rc_rdy_q  <= rc_rdy;
			ext_rdy_q <= ext_rdy;
			irq_flags <= (rd_flags ? 2'h0 : irq_flags) | rise;
		end
	end

	// ---------------------------------------------------------------
	// Bus answer: one cycle after request, error for unmapped address
	// ---------------------------------------------------------------
	assign rd_mux = hit_ext ? {16'h0000, ext_reg[15:0]} :
		hit_rc  ? rc_reg :
		hit_ulp ? {24'h000000, ulp_reg} :
		hit_st  ? {30'h0, rc_rdy, ext_rdy} :
		hit_flg ? {30'h0, irq_flags} :
		hit_msk ? {30'h0, irq_mask} : 32'h0000_0000;

	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_out <= 1'b0;
			wb_err_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_out <= req_now & mapped;
			wb_err_out <= req_now & ~mapped;
			wb_dat_out <= (req_now && !wb_we_in) ? rd_mux : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Outputs to the analog side
	// ---------------------------------------------------------------
	assign ext_run_out      = ext_run;
	assign rc_run_out       = rc_run;
	assign ext_amp_ctrl_out = ext_reg[lfo_pkg::BIT_AMP_CTRL];
	assign ext_pad_xtal_out = ext_reg[lfo_pkg::BIT_PAD_SEL];
	assign ext_out_gate_out = ext_reg[lfo_pkg::BIT_X_OUT_GATE] & ext_run;
	assign rc_out_gate_out  = rc_reg[lfo_pkg::BIT_I_OUT_GATE] & rc_run;
	assign rc_trim_out      = rc_reg[lfo_pkg::TRIM_RC_LSB +: 7];
	assign ulp_trim_out     = ulp_reg[4:0];
	assign ext_ready_out    = ext_rdy;
	assign rc_ready_out     = rc_rdy;
	assign irq_out          = |(irq_flags & irq_mask);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_ext_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
		ext_locked |=> ext_reg == $past(ext_reg))
		else $error("locked crystal register changed");
	chk_rc_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
		rc_locked |=> rc_reg == $past(rc_reg))
		else $error("locked rc register changed");
	chk_ulp_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
		(ulp_locked && trim_loaded) |=> ulp_reg == $past(ulp_reg))
		else $error("locked ulp register changed");
	chk_ready_off_stop: assert property (@(posedge mclk_in) disable iff (!rst_n)
		!ext_run |=> !ext_rdy)
		else $error("crystal ready while stopped");
	chk_run_on_demand: assert property (@(posedge mclk_in) disable iff (!rst_n)
		(ext_cfg.req_run && !ext_req) |-> !ext_run_out)
		else $error("crystal runs without request");
	chk_run_always: assert property (@(posedge mclk_in) disable iff (!rst_n)
		(rc_cfg.enable && !rc_cfg.req_run) |-> rc_run_out)
		else $error("rc not running when enabled");
	chk_rc_irq_rise: assert property (@(posedge mclk_in) disable iff (!rst_n)
		$rose(rc_rdy) |=> irq_flags[lfo_pkg::ST_RC_RDY])
		else $error("rc ready rise lost");
	chk_ext_rdy_sync: assert property (@(posedge mclk_in) disable iff (!rst_n)
		$rose(ext_rdy) |-> $past(ext_cnt_done) && ext_sync == 2'h2)
		else $error("crystal ready before sync delay");
	chk_out_gate: assert property (@(posedge mclk_in) disable iff (!rst_n)
		!ext_reg[lfo_pkg::BIT_X_OUT_GATE] |-> !ext_out_gate_out)
		else $error("crystal output not gated");
	cov_ext_ready: cover property (@(posedge mclk_in) disable iff (!rst_n)
		$rose(ext_rdy));
	cov_rc_ready: cover property (@(posedge mclk_in) disable iff (!rst_n)
		$rose(rc_rdy));
	cov_irq: cover property (@(posedge mclk_in) disable iff (!rst_n)
		$rose(irq_out));

endmodule : lfo_ctrl

//--- pkg/lfo_pkg.sv
// Package: register map, field positions and constants of the 32 kHz control
package lfo_pkg;

	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_EXT_XTAL  = 8'h14;
	localparam logic [7:0] ADDR_INT_RC    = 8'h18;
	localparam logic [7:0] ADDR_ULP       = 8'h1C;
	localparam logic [7:0] ADDR_STATUS    = 8'h30;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h34;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h38;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_ENABLE     = 1;
	localparam int BIT_PAD_SEL    = 2;
	localparam int BIT_X_OUT_GATE = 3;
	localparam int BIT_I_OUT_GATE = 2;
	localparam int BIT_AMP_CTRL   = 5;
	localparam int BIT_REQ_RUN    = 7;
	localparam int BIT_LOCK       = 12;
	localparam int BIT_ULP_LOCK   = 7;
	localparam int STARTUP_LSB    = 8;
	localparam int TRIM_RC_LSB    = 16;

	// ---------------------------------------------------------------
	// Reset values and writable masks
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_EXT_XTAL = 32'h0000_0080;
	localparam logic [31:0] RST_INT_RC   = 32'h003F_0080;
	localparam logic [31:0] WMASK_EXT    = 32'h0000_17AE;
	localparam logic [31:0] WMASK_RC     = 32'h007F_1786;
	localparam logic [31:0] WMASK_ULP    = 32'h0000_009F;

	// ---------------------------------------------------------------
	// Synchronisation delays in oscillator cycles
	// ---------------------------------------------------------------
	localparam int SYNC_EXT = 3;
	localparam int SYNC_RC  = 2;

	// Status and interrupt bit positions
	localparam int ST_EXT_RDY = 0;
	localparam int ST_RC_RDY  = 1;

	typedef struct packed {
		logic        req_run;
		logic        enable;
		logic [2:0]  startup;
	} lfo_osc_cfg_s;

endpackage : lfo_pkg
